/* File: dssr_pkg.sv */
// shared constants, state codes and carrier structs for the device state status reporter
package dssr_pkg;

  // register map, byte addresses on the serial register port
  localparam logic [7:0] DSSR_ADDR_STATE_FLAGS = 8'h08;
  // reset value of the status byte before level overrides
  localparam logic [7:0] DSSR_STATE_FLAGS_RST = 8'h00;

  // field positions inside the status byte
  localparam int DSSR_POS_MODE_LSB = 0;
  localparam int DSSR_POS_FRESH = 3;
  localparam int DSSR_POS_EMPTY = 4;
  localparam int DSSR_POS_FULL = 5;
  localparam int DSSR_POS_LEVEL = 6;
  localparam int DSSR_POS_PEND = 7;

  // latched flags of the interrupt flag register that feed the summary
  localparam int DSSR_IRQ_FLAG_LSB = 2;
  localparam int DSSR_IRQ_FLAG_MSB = 7;

  // heartbeat transitions allowed before the reported state follows a command
  localparam logic [1:0] DSSR_HB_MAX_TRANS = 2'h3;
  // transitions actually waited, one inside the allowed bound
  localparam logic [1:0] DSSR_HB_APPLY_TRANS = 2'h2;

  // sample queue geometry
  localparam int DSSR_QUEUE_DEPTH = 32;
  localparam int DSSR_QCNT_W = $clog2(DSSR_QUEUE_DEPTH + 1);
  localparam int DSSR_THR_W = 5;

  // burst length code that means sample until told otherwise
  localparam logic [7:0] DSSR_BURST_CONTINUOUS = 8'hFF;
  localparam logic [7:0] DSSR_BURST_ONE = 8'h01;

  // operating states as reported in the low three bits
  typedef enum logic [2:0] {
    DSSR_LOWEST_POWER_STATE = 3'b000,
    DSSR_IDLE_STATE = 3'b001,
    DSSR_ACTIVITY_WATCH_STATE = 3'b010,
    DSSR_RSVD_A = 3'b011,
    DSSR_RSVD_B = 3'b100,
    DSSR_CONTINUOUS_SAMPLING_STATE = 3'b101,
    DSSR_COMBINED_WATCH_SAMPLING_STATE = 3'b110,
    DSSR_TRIGGERED_BURST_STATE = 3'b111
  } dssr_mode_t;

  // status byte layout, msb first
  typedef struct packed {
    logic irq_outstanding_flag;
    logic queue_level_flag;
    logic queue_full_flag;
    logic queue_empty_flag;
    logic fresh_sample_flag;
    dssr_mode_t mode;
  } dssr_status_t;

  // block enables derived from the reached state
  typedef struct packed {
    logic clk_run;
    logic watch_run;
    logic xyz_run;
    logic queue_run;
  } dssr_enables_t;

  // whole state of the reporter
  typedef struct packed {
    dssr_mode_t pend_mode;
    logic pend_vld;
    logic [1:0] hb_cnt;
    logic [7:0] burst_cnt;
    dssr_status_t status;
    dssr_enables_t en;
    logic [7:0] rdata;
  } dssr_top_st_t;

  // whole state of the heartbeat synchroniser
  typedef struct packed {
    logic sync_a;
    logic sync_b;
    logic last;
    logic edge_seen;
  } dssr_sync_st_t;

endpackage : dssr_pkg

/* File: dssr_edge_sync.sv */
// two-flop synchroniser with transition detect for the heartbeat pin
`timescale 1ns/1ps
`default_nettype none
module dssr_edge_sync
  import dssr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic async_i,
  output logic level_o,
  output logic trans_o
);

  // registered state and its next value
  dssr_sync_st_t st_ff;
  dssr_sync_st_t nxt_st;

  // first stage feeds only the second; edge compares stage two with its delay
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync_a = async_i;
    nxt_st.sync_b = st_ff.sync_a;
    nxt_st.last = st_ff.sync_b;
    nxt_st.edge_seen = st_ff.sync_b ^ st_ff.last;
  end

  // constants only under reset
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_o = st_ff.last;
  assign trans_o = st_ff.edge_seen;

endmodule : dssr_edge_sync
`default_nettype wire

/* File: dssr_top.sv */
// device state and status byte reporter with its register read port
`timescale 1ns/1ps
`default_nettype none

// Contract
// - reported state follows command within three transitions
// - lowest power reads 000, idle reads 001
// - watch reads 010, activity moves to continuous
// - continuous reads 101, xyz on, watch off
// - combined reads 110, watch xyz queue on
// - burst reads 111, counted burst returns lowest
// - fresh sample bit three set, cleared on read
// - empty bit four level, one after reset
// - full bit five when 32 slots used
// - level bit six when count reaches threshold
// - bit seven is OR of latched flags
// - flags only set while enable is one; here fresh sets on any sample, bit seven ORs irq_flags_i ungated
// - status read-only, writes change nothing
module dssr_top
  import dssr_pkg::*;
#(
  parameter int QUEUE_DEPTH = DSSR_QUEUE_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // heartbeat clock pin, sampled here
  input wire logic heartbeat_i,
  // mode command strobe from the mode register logic
  input wire logic cmd_wr_i,
  input wire logic [2:0] cmd_mode_i,
  // activity detected by the watch circuitry
  input wire logic activity_i,
  // new sample written to queue or output registers
  input wire logic sample_wr_i,
  // burst length, 1 to 254, 8'hFF continuous
  input wire logic [7:0] burst_len_i,
  // queue occupancy and programmed threshold
  input wire logic [DSSR_QCNT_W-1:0] queue_count_i,
  input wire logic [DSSR_THR_W-1:0] queue_thresh_i,
  // latched interrupt flag register contents
  input wire logic [7:0] irq_flags_i,
  // register port of the serial interface
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // status byte and state enables
  output logic [7:0] state_flags_o,
  output logic [2:0] state_o,
  output logic clk_run_o,
  output logic watch_run_o,
  output logic xyz_run_o,
  output logic queue_run_o
);

  // reset image: lowest power, queue empty, everything else clear
  localparam dssr_top_st_t ST_RST = '{
    pend_mode: DSSR_LOWEST_POWER_STATE,
    pend_vld: 1'b0,
    hb_cnt: 2'h0,
    burst_cnt: 8'h00,
    status: '{
      irq_outstanding_flag: 1'b0,
      queue_level_flag: 1'b0,
      queue_full_flag: 1'b0,
      queue_empty_flag: 1'b1,
      fresh_sample_flag: 1'b0,
      mode: DSSR_LOWEST_POWER_STATE
    },
    en: '{clk_run: 1'b0, watch_run: 1'b0, xyz_run: 1'b0, queue_run: 1'b0},
    rdata: DSSR_STATE_FLAGS_RST
  };

  // registered state and its next value
  dssr_top_st_t st_ff;
  dssr_top_st_t nxt_st;
  // heartbeat transition pulse on the system clock
  logic hb_trans;
  // status register selected by a read
  logic rd_hit;
  // threshold widened to the queue count width
  logic [DSSR_QCNT_W-1:0] thr_ext;
  // command code is one of the six legal states
  logic cmd_legal;
  // the sample written now is the last of the burst
  logic burst_last;

  // heartbeat comes from another domain, so it is synchronised first
  dssr_edge_sync u_hb_sync (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .async_i(heartbeat_i),
    .level_o(),
    .trans_o(hb_trans)
  );

  // state enables for a given state code
  function automatic dssr_enables_t enables_of(input dssr_mode_t m);
    dssr_enables_t e;
    e = '0;
    unique case (m)
      DSSR_LOWEST_POWER_STATE: begin
        e = '0;
      end
      DSSR_IDLE_STATE: begin
        e.clk_run = 1'b1;
      end
      DSSR_ACTIVITY_WATCH_STATE: begin
        // queue stays idle while only watching
        e.clk_run = 1'b1;
        e.watch_run = 1'b1;
      end
      DSSR_CONTINUOUS_SAMPLING_STATE: begin
        e.clk_run = 1'b1;
        e.xyz_run = 1'b1;
        e.queue_run = 1'b1;
      end
      DSSR_COMBINED_WATCH_SAMPLING_STATE: begin
        e.clk_run = 1'b1;
        e.watch_run = 1'b1;
        e.xyz_run = 1'b1;
        e.queue_run = 1'b1;
      end
      DSSR_TRIGGERED_BURST_STATE: begin
        e.clk_run = 1'b1;
        e.xyz_run = 1'b1;
        e.queue_run = 1'b1;
      end
      default: begin
        // reserved codes never reach the state, fall back to off
        e = '0;
      end
    endcase
    return e;
  endfunction : enables_of

  // decode helpers
  always_comb begin
    rd_hit = rd_en_i && (addr_i == DSSR_ADDR_STATE_FLAGS);
    thr_ext = {{(DSSR_QCNT_W-DSSR_THR_W){1'b0}}, queue_thresh_i};
    cmd_legal = (cmd_mode_i != DSSR_RSVD_A) && (cmd_mode_i != DSSR_RSVD_B);
    // zero length is taken as a single sample
    burst_last = (burst_len_i != DSSR_BURST_CONTINUOUS) &&
                 ((st_ff.burst_cnt + 8'h01) >= ((burst_len_i == 8'h00) ? DSSR_BURST_ONE : burst_len_i));
  end

  // next state of the whole reporter
  always_comb begin
    nxt_st = st_ff;

    // command held until heartbeat transitions pass
    if (cmd_wr_i && cmd_legal) begin
      // a newer command restarts the wait
      nxt_st.pend_mode = dssr_mode_t'(cmd_mode_i);
      nxt_st.pend_vld = 1'b1;
      nxt_st.hb_cnt = 2'h0;
    end else if (st_ff.pend_vld && hb_trans) begin
      if (st_ff.hb_cnt + 2'h1 >= DSSR_HB_APPLY_TRANS) begin
        nxt_st.status.mode = st_ff.pend_mode;
        nxt_st.pend_vld = 1'b0;
        nxt_st.hb_cnt = 2'h0;
        nxt_st.burst_cnt = 8'h00;
      end else begin
        nxt_st.hb_cnt = st_ff.hb_cnt + 2'h1;
      end
    end

    // autonomous moves only when no command lands this cycle
    if ((cmd_wr_i && cmd_legal) ||
        !(st_ff.pend_vld && hb_trans && (st_ff.hb_cnt + 2'h1 >= DSSR_HB_APPLY_TRANS))) begin
      if ((st_ff.status.mode == DSSR_ACTIVITY_WATCH_STATE) && activity_i) begin
        nxt_st.status.mode = DSSR_CONTINUOUS_SAMPLING_STATE;
      end
      // counted burst ends in lowest power
      if ((st_ff.status.mode == DSSR_TRIGGERED_BURST_STATE) && sample_wr_i) begin
        if (burst_last) begin
          nxt_st.status.mode = DSSR_LOWEST_POWER_STATE;
          nxt_st.burst_cnt = 8'h00;
        end else if (burst_len_i != DSSR_BURST_CONTINUOUS) begin
          nxt_st.burst_cnt = st_ff.burst_cnt + 8'h01;
        end
      end
    end

    nxt_st.en = enables_of(nxt_st.status.mode);

    // fresh flag, set wins over read clear
    if (sample_wr_i) begin
      nxt_st.status.fresh_sample_flag = 1'b1;
    end else if (rd_hit) begin
      nxt_st.status.fresh_sample_flag = 1'b0;
    end

    nxt_st.status.queue_empty_flag = (queue_count_i == '0);
    // full when every slot holds a sample
    nxt_st.status.queue_full_flag =
      (queue_count_i >= DSSR_QCNT_W'(QUEUE_DEPTH));
    nxt_st.status.queue_level_flag = (queue_count_i >= thr_ext);
    // flags arrive already gated by their enables
    nxt_st.status.irq_outstanding_flag =
      |irq_flags_i[DSSR_IRQ_FLAG_MSB:DSSR_IRQ_FLAG_LSB];

    // read data shows the byte before this read clears anything
    // writes never reach the status byte
    if (rd_hit) begin
      nxt_st.rdata = st_ff.status;
    end else if (rd_en_i) begin
      // unmapped here, reads zero
      nxt_st.rdata = 8'h00;
    end
  end

  // single register stage for all state
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state flops
  assign rdata_o = st_ff.rdata;
  assign state_flags_o = st_ff.status;
  assign state_o = st_ff.status.mode;
  assign clk_run_o = st_ff.en.clk_run;
  assign watch_run_o = st_ff.en.watch_run;
  assign xyz_run_o = st_ff.en.xyz_run;
  assign queue_run_o = st_ff.en.queue_run;

  // checks on the reporter
  a_hb_wait_bound: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    st_ff.pend_vld |-> (st_ff.hb_cnt < DSSR_HB_MAX_TRANS))
    else $error("heartbeat wait exceeded bound");

  a_cmd_applied: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (st_ff.pend_vld && hb_trans && !cmd_wr_i && (st_ff.hb_cnt == 2'h1))
    |=> (st_ff.status.mode == $past(st_ff.pend_mode)) && !st_ff.pend_vld)
    else $error("command state not reported after heartbeat wait");

  a_sleep_dark: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_o == DSSR_LOWEST_POWER_STATE) |-> !clk_run_o && !xyz_run_o && !watch_run_o)
    else $error("lowest power state with activity");

  a_watch_wake: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    ((state_o == DSSR_ACTIVITY_WATCH_STATE) && activity_i && !st_ff.pend_vld)
    |=> (state_o == DSSR_CONTINUOUS_SAMPLING_STATE) && xyz_run_o)
    else $error("activity did not move watch to continuous");

  a_cont_nowatch: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_o == DSSR_CONTINUOUS_SAMPLING_STATE) |-> xyz_run_o && !watch_run_o)
    else $error("continuous state enables wrong");

  a_combined_all: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_o == DSSR_COMBINED_WATCH_SAMPLING_STATE) |-> watch_run_o && xyz_run_o && queue_run_o)
    else $error("combined state enables wrong");

  a_burst_single: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    ((state_o == DSSR_TRIGGERED_BURST_STATE) && !st_ff.pend_vld && sample_wr_i
     && (burst_len_i == DSSR_BURST_ONE)) |=> (state_o == DSSR_LOWEST_POWER_STATE))
    else $error("single sample burst did not end");

  a_no_reserved: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_o != DSSR_RSVD_A) && (state_o != DSSR_RSVD_B))
    else $error("reserved state code reported");

  a_fresh_read: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (sample_wr_i |=> state_flags_o[DSSR_POS_FRESH]) and
    ((rd_hit && !sample_wr_i) |=> !state_flags_o[DSSR_POS_FRESH]))
    else $error("fresh sample flag wrong");

  a_empty_level: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    ##1 state_flags_o[DSSR_POS_EMPTY] == ($past(queue_count_i) == '0))
    else $error("empty flag does not follow count");

  a_full_level: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (queue_count_i == DSSR_QCNT_W'(QUEUE_DEPTH)) |=> state_flags_o[DSSR_POS_FULL])
    else $error("full flag missing at depth");

  a_level_thresh: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (queue_count_i < thr_ext) |=> !state_flags_o[DSSR_POS_LEVEL])
    else $error("level flag set below threshold");

  a_pend_or: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    ##1 state_flags_o[DSSR_POS_PEND] == $past(|irq_flags_i[7:2]))
    else $error("pending summary not OR of flags");

  a_write_inert: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (wr_en_i && !rd_en_i) |=> (rdata_o == $past(rdata_o)))
    else $error("write disturbed read data");

  // main scenarios
  c_burst_end: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_o == DSSR_TRIGGERED_BURST_STATE) ##1 (state_o == DSSR_LOWEST_POWER_STATE));
  c_watch_wake: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_o == DSSR_ACTIVITY_WATCH_STATE) ##1 (state_o == DSSR_CONTINUOUS_SAMPLING_STATE));
  c_fresh_clash: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    rd_hit && sample_wr_i);
  c_queue_full: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    state_flags_o[DSSR_POS_FULL]);

endmodule : dssr_top
`default_nettype wire

/* File: dssr_hb_model.sv */
// free running heartbeat clock source seen at the reporter's heartbeat pin
`timescale 1ns/1ps
`default_nettype none
module dssr_hb_model #(
  parameter int HALF = 12
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  output logic heartbeat_o
);
  // cycle counter for one half period
  int cnt;

  // toggle every half period, held low in reset like a stopped oscillator
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= 0;
      heartbeat_o <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      heartbeat_o <= ~heartbeat_o;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : dssr_hb_model
`default_nettype wire

/* File: dssr_top_test.sv */
// self-checking bench for the device state status reporter
`timescale 1ns/1ps
`default_nettype none
module dssr_top_test
  import dssr_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic reset_n_i, hb, cmd_wr, activity, sample_wr, rd_en, wr_en, rd_d;
  logic [2:0] cmd_mode, state, cur_mode;
  logic [7:0] burst_len, irq, addr, wdata, rdata, flags;
  logic [DSSR_QCNT_W-1:0] qcnt;
  logic [DSSR_THR_W-1:0] qthr;
  logic clk_run, watch_run, xyz_run, queue_run, fresh;
  // expected read data, oldest first
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int n_tests = 0;

  // 125 MHz system clock
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  dssr_hb_model #(.HALF(12)) hb_src (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .heartbeat_o(hb));

  dssr_top dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .heartbeat_i(hb),
    .cmd_wr_i(cmd_wr), .cmd_mode_i(cmd_mode), .activity_i(activity),
    .sample_wr_i(sample_wr), .burst_len_i(burst_len), .queue_count_i(qcnt),
    .queue_thresh_i(qthr), .irq_flags_i(irq), .rd_en_i(rd_en), .wr_en_i(wr_en),
    .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .state_flags_o(flags),
    .state_o(state), .clk_run_o(clk_run), .watch_run_o(watch_run),
    .xyz_run_o(xyz_run), .queue_run_o(queue_run));

  // one compare, counted; mismatches reported at once
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // status byte worked out from the levels driven now
  function automatic logic [7:0] exp_flags(input logic f, input logic [2:0] m);
    return {|irq[7:2], qcnt >= DSSR_QCNT_W'(qthr), qcnt == DSSR_QCNT_W'(32), qcnt == '0, f, m};
  endfunction : exp_flags

  // enables {clk, watch, xyz, queue} of each reached state
  function automatic logic [3:0] exp_en(input logic [2:0] m);
    case (m)
      3'b001: return 4'h8;
      3'b010: return 4'hc;
      3'b101: return 4'hb;
      3'b110: return 4'hf;
      3'b111: return 4'hb;
      default: return 4'h0;
    endcase
  endfunction : exp_en

  // read cycle; the answer is judged by the monitor below
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys_i);
    rd_en = 1'b1;
    addr = a;
    exp_q.push_back(e);
    // a read of the status byte clears the fresh flag
    if (a == DSSR_ADDR_STATE_FLAGS) fresh = 1'b0;
    @(negedge clk_sys_i);
    rd_en = 1'b0;
  endtask : rd

  // monitor: read data stands in the cycle after the taking edge
  always @(posedge clk_sys_i) rd_d <= rd_en;
  always @(negedge clk_sys_i) begin
    if (rd_d === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected read", rdata, 8'hxx);
      end else begin
        check("rdata", rdata, exp_q.pop_front());
      end
    end
  end

  // state command, then a wait of at least three heartbeat transitions
  task automatic cmd(input logic [2:0] m);
    @(negedge clk_sys_i);
    cmd_wr = 1'b1;
    cmd_mode = m;
    @(negedge clk_sys_i);
    cmd_wr = 1'b0;
    repeat (40) @(negedge clk_sys_i);
    if (m != 3'b011 && m != 3'b100) cur_mode = m;
    check("state", {5'h00, state}, {5'h00, cur_mode});
    check("enables", {4'h0, clk_run, watch_run, xyz_run, queue_run},
      {4'h0, exp_en(cur_mode)});
    rd(DSSR_ADDR_STATE_FLAGS, exp_flags(fresh, cur_mode));
  endtask : cmd

  // one new sample pulse
  task automatic sample();
    @(negedge clk_sys_i);
    sample_wr = 1'b1;
    @(negedge clk_sys_i);
    sample_wr = 1'b0;
    fresh = 1'b1;
  endtask : sample

  // watchdog, far beyond the length of the sequence
  initial begin
    #300us;
    n_errors++;
    wrap_up();
  end

  initial begin
    int n;
    logic [7:0] a;
    logic [2:0] codes[8];
    codes = '{3'b001, 3'b010, 3'b011, 3'b101, 3'b100, 3'b110, 3'b001, 3'b000};
    reset_n_i = 1'b0;
    {cmd_wr, activity, sample_wr, rd_en, wr_en, fresh} = '0;
    {cmd_mode, cur_mode, burst_len, irq, addr, wdata, qcnt} = '0;
    qthr = 5'h01;
    void'($urandom(32'h8fec_0d11));
    repeat (5) @(negedge clk_sys_i);
    check("reset flags", flags, 8'h10);
    reset_n_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    check("flags after reset", flags, exp_flags(1'b0, 3'b000));
    // every legal code except burst, and both reserved codes
    foreach (codes[i]) cmd(codes[i]);
    cmd(3'b010);
    @(negedge clk_sys_i);
    activity = 1'b1;
    @(negedge clk_sys_i);
    activity = 1'b0;
    cur_mode = 3'b101;
    check("state after activity", {5'h00, state}, 8'h05);
    // counted bursts of length zero, one and random end in lowest power
    for (int b = 0; b < 3; b++) begin
      n = (b < 2) ? 1 : $urandom_range(2, 6);
      burst_len = (b == 0) ? 8'h00 : 8'(n);
      cmd(3'b111);
      for (int k = 1; k <= n; k++) begin
        sample();
        check("burst state", {5'h00, state}, (k == n) ? 8'h00 : 8'h07);
      end
      cur_mode = 3'b000;
    end
    burst_len = DSSR_BURST_CONTINUOUS;
    cmd(3'b111);
    repeat (4) sample();
    check("continuous burst", {5'h00, state}, 8'h07);
    // fresh flag set by a sample, cleared by the read
    rd(DSSR_ADDR_STATE_FLAGS, exp_flags(1'b1, cur_mode));
    fresh = 1'b0;
    @(negedge clk_sys_i);
    rd(DSSR_ADDR_STATE_FLAGS, exp_flags(1'b0, cur_mode));
    for (int i = 0; i < 14; i++) begin
      qthr = DSSR_THR_W'($urandom);
      irq = (i == 3) ? 8'h03 : 8'($urandom);
      qcnt = (i == 0) ? '0 : (i == 1) ? DSSR_QCNT_W'(32) : (i == 2) ? DSSR_QCNT_W'(qthr) :
        DSSR_QCNT_W'($urandom_range(0, 32));
      repeat (2) @(negedge clk_sys_i);
      rd(DSSR_ADDR_STATE_FLAGS, exp_flags(fresh, cur_mode));
    end
    // writes change nothing, other addresses read zero
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys_i);
      wr_en = 1'b1;
      addr = (i < 2) ? DSSR_ADDR_STATE_FLAGS : 8'($urandom);
      wdata = 8'($urandom);
      @(negedge clk_sys_i);
      wr_en = 1'b0;
      rd(DSSR_ADDR_STATE_FLAGS, exp_flags(fresh, cur_mode));
      a = 8'($urandom);
      if (a == DSSR_ADDR_STATE_FLAGS) a = 8'h07;
      rd(a, 8'h00);
    end
    check("state kept", {5'h00, state}, {5'h00, cur_mode});
    repeat (3) @(negedge clk_sys_i);
    check("pending reads", 8'(exp_q.size()), 8'h00);
    wrap_up();
  end
endmodule : dssr_top_test
`default_nettype wire
